// file: rtl/wake_pkg.sv
// Shared constants and types for the wake detection block
package wake_pkg;

  // ==========================================================
  // Register offsets (byte addresses on the bus)
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ISTAT  = 8'h04;
  localparam logic [7:0] OFF_IMASK  = 8'h08;
  localparam logic [7:0] OFF_CMD    = 8'h0c;
  localparam logic [7:0] OFF_OFFS0  = 8'h10;
  localparam logic [7:0] OFF_OFFS1  = 8'h14;
  localparam logic [7:0] OFF_CRC0   = 8'h18;
  localparam logic [7:0] OFF_MASK   = 8'h40;
  localparam logic [7:0] OFF_MASKEND = 8'hc0;

  // ==========================================================
  // Control and status fields
  localparam int BIT_MAGIC_EN  = 0;
  localparam int BIT_FRAME_EN  = 1;
  localparam int BIT_MAGIC_RX  = 4;
  localparam int BIT_FRAME_RX  = 5;
  localparam int BIT_UNI_EN    = 9;
  localparam int ISTAT_MAGIC   = 0;
  localparam int ISTAT_FRAME   = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0203;
  localparam logic [31:0] CMD_WMASK  = 32'hdddd_dddd;
  localparam logic [1:0]  ATYPE_UNI  = 2'h0;
  localparam logic [1:0]  ATYPE_MULTI = 2'h2;

  // ==========================================================
  // Frame layout and magic pattern
  localparam int NUM_FILTERS = 8;
  localparam int MASK_BITS   = 128;
  localparam logic [10:0] MAGIC_START = 11'h00c;
  localparam logic [10:0] DA_LEN      = 11'h006;
  localparam logic [2:0]  SYNC_LAST   = 3'h5;
  localparam logic [2:0]  ADDR_LAST   = 3'h5;
  localparam logic [3:0]  REP_LAST    = 4'hf;
  localparam logic [7:0]  SYNC_BYTE   = 8'hff;
  localparam logic [15:0] CRC_POLY    = 16'h8005;
  localparam logic [15:0] CRC_INIT    = 16'hffff;

  typedef enum logic [0:0] {
    MS_SYNC,
    MS_ADDR
  } magic_state_type;

endpackage

// file: rtl/wake_crc16.sv
// One-byte CRC-16 update step, MSB first
`timescale 1ns/1ns
module wake_crc16 #(
  parameter logic [15:0] POLY = wake_pkg::CRC_POLY
) (
  input  wire logic [15:0] crcIn,
  input  wire logic [7:0]  dataIn,
  output logic      [15:0] crcOut
);

  // ==========================================================
  // Eight serial shifts folded into one cycle
  always_comb begin
    logic [15:0] c;
    c = crcIn;
    for (int b = 7; b >= 0; b--) begin
      if (c[15] ^ dataIn[b]) begin
        c = {c[14:0], 1'b0} ^ POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crcOut = c;
  end

endmodule

// file: rtl/wake_detect.sv
// Wakeup frame filters and magic packet detector with Wishbone registers
//
// Overview of operation
// - Address type 00 unicast, 10 multicast, x1 any frame passing filter.
// - A filter counts only while its command bit 0 is set.
// - Pattern offset selects first checked byte; zero is first DA byte.
// - CRC-16 over masked bytes equal to expected value means match.
// - Frame wakes only with frame wake enable and qualifying cases.
// - Enabled matching filter on broadcast wakes despite broadcast reject.
// - Global unicast enable makes matching unicast frames wake regardless.
// - Passed-filter frames wake per address type multicast, unicast, any.
// - Magic enable stops normal reception; only magic pattern is sought (here frame filters still wake if frame wake is enabled).
// - Magic packet sets flag, requests full power, issues remote wakeup.
// - Magic packets must address own MAC or broadcast.
// - Multicast frames holding sixteen address copies are also accepted.
// - After DA and SA, six FF bytes then sixteen address copies.
// - Mask bit j feeds frame byte offset plus j into the CRC.
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ns
module wake_detect (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  // Receive byte stream from the MAC
  input  wire logic        rxValid,
  input  wire logic        rxSof,
  input  wire logic        rxEof,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxFrameOk,
  input  wire logic        rxPassFilter,
  input  wire logic [47:0] nodeAddr,
  // Power management side
  output logic             rxDisable,
  output logic             wakeRequest,
  output logic             remoteWakeup,
  output logic             fullPowerReq,
  output logic             irq
);

  localparam int NF = wake_pkg::NUM_FILTERS;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] addrByte(input logic [47:0] a,
                                          input logic [2:0]  k);
    addrByte = a[8*(5-k) +: 8];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // ==========================================================
  // Bus decode
  logic        ack_q;
  logic [31:0] ctrl_q;
  logic [31:0] cmd_q;
  logic [63:0] offs_q;
  logic [127:0] crcExp_q;
  logic [1:0]  istat_q;
  logic [1:0]  imask_q;
  logic [31:0] dat_q;
  logic [wake_pkg::MASK_BITS-1:0] maskMem [NF];

  wire        wbReq    = cyc_i & stb_i & ~ack_q;
  wire        wrEn     = wbReq & we_i;
  wire        rdEn     = wbReq & ~we_i;
  wire [7:0]  wordAddr = {adr_i[7:2], 2'b00};
  wire        inMask   = wordAddr >= wake_pkg::OFF_MASK &&
                         wordAddr <  wake_pkg::OFF_MASKEND;
  wire [7:0]  maskRel  = wordAddr - wake_pkg::OFF_MASK;
  wire [2:0]  maskFlt  = maskRel[6:4];
  wire [1:0]  maskWord = maskRel[3:2];
  wire        crcHit   = wordAddr >= wake_pkg::OFF_CRC0 &&
                         wordAddr <  wake_pkg::OFF_MASK;
  wire [7:0]  crcRel   = wordAddr - wake_pkg::OFF_CRC0;
  wire        crcInRng = crcRel[7:2] < 6'h04;
  wire [1:0]  crcWord  = crcRel[3:2];
  wire        istatRd  = rdEn && wordAddr == wake_pkg::OFF_ISTAT;

  // Read selection; unmapped words read as zero
  wire [31:0] maskRd  = maskMem[maskFlt][32*maskWord +: 32];
  wire [31:0] rdData  =
    wordAddr == wake_pkg::OFF_CTRL  ? ctrl_q :
    wordAddr == wake_pkg::OFF_ISTAT ? {30'h0, istat_q} :
    wordAddr == wake_pkg::OFF_IMASK ? {30'h0, imask_q} :
    wordAddr == wake_pkg::OFF_CMD   ? cmd_q :
    wordAddr == wake_pkg::OFF_OFFS0 ? offs_q[31:0] :
    wordAddr == wake_pkg::OFF_OFFS1 ? offs_q[63:32] :
    (crcHit && crcInRng)            ? crcExp_q[32*crcWord +: 32] :
    inMask                          ? maskRd : 32'h0;

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= wbReq;
      if (rdEn) begin
        dat_q <= rdData;
      end
    end
  end
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ==========================================================
  // Configuration registers
  wire magicEn = ctrl_q[wake_pkg::BIT_MAGIC_EN];
  wire frameEn = ctrl_q[wake_pkg::BIT_FRAME_EN];
  wire uniEn   = ctrl_q[wake_pkg::BIT_UNI_EN];
  logic magicWake;
  logic frameWake;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_q    <= 32'h0;
      offs_q   <= 64'h0;
      crcExp_q <= 128'h0;
      imask_q  <= 2'h0;
    end else if (wrEn) begin
      if (wordAddr == wake_pkg::OFF_CMD) begin
        cmd_q <= merge(cmd_q, dat_i, sel_i) & wake_pkg::CMD_WMASK;
      end
      if (wordAddr == wake_pkg::OFF_OFFS0) begin
        offs_q[31:0] <= merge(offs_q[31:0], dat_i, sel_i);
      end
      if (wordAddr == wake_pkg::OFF_OFFS1) begin
        offs_q[63:32] <= merge(offs_q[63:32], dat_i, sel_i);
      end
      if (crcHit && crcInRng) begin
        crcExp_q[32*crcWord +: 32] <=
          merge(crcExp_q[32*crcWord +: 32], dat_i, sel_i);
      end
      if (wordAddr == wake_pkg::OFF_IMASK) begin
        imask_q <= dat_i[1:0];
      end
    end
  end

  // Byte masks have no reset; software loads them before enabling
  always_ff @(posedge clk) begin
    if (wrEn && inMask) begin
      maskMem[maskFlt][32*maskWord +: 32] <= merge(maskRd, dat_i, sel_i);
    end
  end

  // Control: enables by write, received flags set by hardware and
  // cleared by writing one; a set in the same cycle wins
  wire [31:0] ctrlWr = merge(ctrl_q, dat_i, sel_i);
  wire ctrlWrite = wrEn && wordAddr == wake_pkg::OFF_CTRL;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= wake_pkg::CTRL_RESET;
    end else begin
      if (ctrlWrite) begin
        ctrl_q <= (ctrlWr & wake_pkg::CTRL_WMASK) |
                  (ctrl_q & ~wake_pkg::CTRL_WMASK & ~ctrlWr);
      end
      if (magicWake) begin
        ctrl_q[wake_pkg::BIT_MAGIC_RX] <= 1'b1;
      end
      if (frameWake) begin
        ctrl_q[wake_pkg::BIT_FRAME_RX] <= 1'b1;
      end
    end
  end

  // Interrupt status cleared by reading it; events win over the read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      istat_q <= 2'h0;
    end else begin
      istat_q <= (istatRd ? 2'h0 : istat_q) | {frameWake, magicWake};
    end
  end
  assign irq = |(istat_q & imask_q);

  // ==========================================================
  // Frame position and destination address classification
  logic [10:0] pos_q;
  logic        broadcast_reject_q;
  logic        mcast_q;
  logic        own_q;
  logic        pass_q;
  logic        ok_q;
  logic        eval_q;

  wire [10:0] pos     = rxSof ? 11'h0 : pos_q;
  wire        inDa    = pos < wake_pkg::DA_LEN;
  wire        byteFf  = rxData == wake_pkg::SYNC_BYTE;
  wire        byteOwn = rxData == addrByte(nodeAddr, pos[2:0]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos_q   <= 11'h0;
      broadcast_reject_q <= 1'b0;
      mcast_q <= 1'b0;
      own_q   <= 1'b0;
      pass_q  <= 1'b0;
      ok_q    <= 1'b0;
      eval_q  <= 1'b0;
    end else begin
      eval_q <= rxValid & rxEof;
      if (rxValid) begin
        if (pos != 11'h7ff) begin
          pos_q <= pos + 11'h1;
        end
        if (rxSof) begin
          mcast_q <= rxData[0];
        end
        if (inDa) begin
          broadcast_reject_q <= (rxSof | broadcast_reject_q) & byteFf;
          own_q   <= (rxSof | own_q) & byteOwn;
        end
        if (rxEof) begin
          pass_q <= rxPassFilter;
          ok_q   <= rxFrameOk;
        end
      end
    end
  end

  // ==========================================================
  // Wakeup frame filters
  logic [NF-1:0] hitVec;
  logic [NF-1:0] matchVec;
  wire isUni   = ~mcast_q;
  wire isMulti = mcast_q & ~broadcast_reject_q;

  for (genvar i = 0; i < NF; i++) begin : g_filter
    logic [15:0] crc_q;
    logic [15:0] crcNext;
    wire        en    = cmd_q[4*i];
    wire [1:0]  atype = cmd_q[4*i+2 +: 2];
    wire [7:0]  offs  = offs_q[8*i +: 8];
    wire [10:0] rel   = pos - {3'h0, offs};
    wire        win   = pos >= {3'h0, offs} && rel < 11'd128;
    wire        take  = rxValid & win & maskMem[i][rel[6:0]];
    wire [15:0] base  = rxSof ? wake_pkg::CRC_INIT : crc_q;

    wake_crc16 u_crc (
      .crcIn  (base),
      .dataIn (rxData),
      .crcOut (crcNext)
    );

    // Unselected bytes leave the running CRC alone
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        crc_q <= wake_pkg::CRC_INIT;
      end else if (rxValid) begin
        crc_q <= take ? crcNext : base;
      end
    end

    // Qualifying cases of the wake table
    wire crcOk  = crc_q == crcExp_q[16*i +: 16];
    wire byType = atype[0] |
                  (atype == wake_pkg::ATYPE_MULTI & isMulti) |
                  (atype == wake_pkg::ATYPE_UNI & isUni);
    assign matchVec[i] = en & crcOk;
    assign hitVec[i] = en & crcOk &
                       (broadcast_reject_q |
                        (uniEn & isUni) |
                        (pass_q & byType));
  end

  // One judgement per frame, after its last byte
  assign frameWake = eval_q & ok_q & frameEn & (|hitVec);

  // ==========================================================
  // Magic packet search
  wake_pkg::magic_state_type state_q;
  logic [2:0] ffCnt_q;
  logic [2:0] octet_q;
  logic [3:0] rep_q;
  logic       seen_q;

  wire afterSa  = pos >= wake_pkg::MAGIC_START;
  wire addrOk   = rxData == addrByte(nodeAddr, octet_q);
  wire firstCp  = octet_q == 3'h0 && rep_q == 4'h0;
  wire lastCp   = octet_q == wake_pkg::ADDR_LAST &&
                  rep_q == wake_pkg::REP_LAST;

  // A broken copy drops back to looking for the sync run; an FF there
  // may already start the next run
  always_ff @(posedge clk) begin
    if (!rst_n || (rxValid && rxSof)) begin
      state_q <= wake_pkg::MS_SYNC;
      ffCnt_q <= 3'h0;
      octet_q <= 3'h0;
      rep_q   <= 4'h0;
      seen_q  <= 1'b0;
    end else if (rxValid && afterSa && magicEn && !seen_q) begin
      case (state_q)
        wake_pkg::MS_SYNC: begin
          if (!byteFf) begin
            ffCnt_q <= 3'h0;
          end else if (ffCnt_q == wake_pkg::SYNC_LAST) begin
            state_q <= wake_pkg::MS_ADDR;
          end else begin
            ffCnt_q <= ffCnt_q + 3'h1;
          end
        end
        wake_pkg::MS_ADDR: begin
          if (addrOk) begin
            seen_q  <= lastCp;
            octet_q <= (octet_q == wake_pkg::ADDR_LAST) ? 3'h0 :
                       octet_q + 3'h1;
            if (octet_q == wake_pkg::ADDR_LAST) begin
              rep_q <= rep_q + 4'h1;
            end
          end else if (!(firstCp && byteFf)) begin
            state_q <= wake_pkg::MS_SYNC;
            ffCnt_q <= {2'h0, byteFf};
            octet_q <= 3'h0;
            rep_q   <= 4'h0;
          end
        end
        default: begin
          state_q <= wake_pkg::MS_SYNC;
        end
      endcase
    end
  end

  // Own address, broadcast, or any multicast carrying the pattern
  assign magicWake = eval_q & ok_q & magicEn & seen_q &
                     (own_q | mcast_q);

  // ==========================================================
  // Wake outputs, one-cycle pulses from flip-flops
  logic wake_q;
  logic remote_q;
  logic full_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_q   <= 1'b0;
      remote_q <= 1'b0;
      full_q   <= 1'b0;
    end else begin
      wake_q   <= frameWake | magicWake;
      remote_q <= frameWake | magicWake;
      full_q   <= magicWake;
    end
  end
  assign wakeRequest  = wake_q;
  assign remoteWakeup = remote_q;
  assign fullPowerReq = full_q;
  // Normal path stays blocked until software clears the enable
  assign rxDisable    = magicEn;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged next cycle");
  a_wake_needs_enable: assert property (
    wakeRequest && !$past(magicWake) |-> $past(frameEn))
    else $error("frame wake without frame enable");
  a_wake_at_eof: assert property (wakeRequest |-> $past(rxEof, 2))
    else $error("wake not tied to a frame end");
  a_filter_enabled: assert property (
    frameWake |-> |matchVec)
    else $error("frame wake with no filter hit");
  a_broadcast_reject_wakes: assert property (
    eval_q && ok_q && frameEn && broadcast_reject_q && |matchVec |=> wakeRequest)
    else $error("broadcast match did not wake");
  a_uni_global: assert property (
    eval_q && ok_q && frameEn && uniEn && isUni &&
    |matchVec |=> wakeRequest)
    else $error("global unicast match did not wake");
  a_magic_flag: assert property (
    magicWake |=> ctrl_q[wake_pkg::BIT_MAGIC_RX] && fullPowerReq
      && remoteWakeup)
    else $error("magic packet not reported");
  a_magic_addr: assert property (
    fullPowerReq |-> $past(own_q || mcast_q))
    else $error("magic accepted for foreign address");
  a_rx_blocked: assert property (
    $rose(ctrl_q[wake_pkg::BIT_MAGIC_EN]) |-> rxDisable)
    else $error("reception not blocked in magic mode");

  c_frame_wake: cover property (frameWake);
  c_magic_wake: cover property (magicWake);
  c_irq_raised: cover property ($rose(irq));
  c_magic_sync: cover property (state_q == wake_pkg::MS_ADDR);

endmodule

// file: verif/mac_rx_model.sv
// Receive byte stream source standing in for the MAC receive path
`timescale 1ns/1ns
module mac_rx_model (
  input  wire logic clk,
  output logic      rxValid,
  output logic      rxSof,
  output logic      rxEof,
  output logic [7:0] rxData,
  output logic      rxFrameOk,
  output logic      rxPassFilter
);
  logic [7:0] frame[$];

  // ==========================================================
  // Idle levels at time zero
  initial begin
    rxValid = 1'b0;
    rxSof = 1'b0;
    rxEof = 1'b0;
    rxData = 8'h00;
    rxFrameOk = 1'b0;
    rxPassFilter = 1'b0;
  end

  // ==========================================================
  // Frame sender; random idle gaps make the source sometimes slow
  task automatic sendFrame(input logic ok, input logic pass);
    for (int i = 0; i < frame.size(); i++) begin
      if ($urandom_range(3) == 0) begin
        rxValid <= 1'b0;
        rxData <= ~rxData;  // No stale byte while idle
        @(posedge clk);
      end
      rxValid <= 1'b1;
      rxSof <= (i == 0);
      rxEof <= (i == frame.size() - 1);
      rxData <= frame[i];
      // Verdicts only mean something on the last byte
      rxFrameOk <= (i == frame.size() - 1) ? ok : ~ok;
      rxPassFilter <= (i == frame.size() - 1) ? pass : ~pass;
      @(posedge clk);
    end
    rxValid <= 1'b0;
    rxSof <= 1'b0;
    rxEof <= 1'b0;
    rxData <= ~frame[frame.size() - 1];
    repeat (4) @(posedge clk);
  endtask
endmodule

// file: verif/wake_detect_test.sv
// Self-checking bench for the wake detection block
`timescale 1ns/1ns
module wake_detect_test;
  logic        clk;
  logic        rst_n;
  logic [7:0]  adr_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic [3:0]  sel_i;
  logic        we_i, cyc_i, stb_i, ack_o;
  logic        rxValid, rxSof, rxEof, rxFrameOk, rxPassFilter;
  logic [7:0]  rxData;
  logic [47:0] nodeAddr;
  logic        rxDisable, wakeRequest, remoteWakeup, fullPowerReq, irq;
  logic [2:0]  notes[$];
  logic [31:0] rd;
  int          failures;
  int          num_checks;

  wake_detect u_wake_detect (.clk(clk), .rst_n(rst_n), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .rxValid(rxValid),
    .rxSof(rxSof), .rxEof(rxEof), .rxData(rxData), .rxFrameOk(rxFrameOk),
    .rxPassFilter(rxPassFilter), .nodeAddr(nodeAddr),
    .rxDisable(rxDisable), .wakeRequest(wakeRequest),
    .remoteWakeup(remoteWakeup), .fullPowerReq(fullPowerReq), .irq(irq));
  mac_rx_model u_mac_rx_model (.clk(clk), .rxValid(rxValid), .rxSof(rxSof),
    .rxEof(rxEof), .rxData(rxData), .rxFrameOk(rxFrameOk),
    .rxPassFilter(rxPassFilter));

  // ==========================================================
  // Clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // ==========================================================
  // Compare tasks and verdict
  task automatic checkReg(input string what, input logic [31:0] e,
                          input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic checkWake(input logic [2:0] e, input logic [2:0] g);
    checkReg("wake outputs", {29'h0, e}, {29'h0, g});
  endtask
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Wishbone classic cycle; holds the request until ack is sampled
  task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s,
                    input logic [31:0] d);
    int n;
    n = 0;
    adr_i <= a;
    we_i <= w;
    sel_i <= s;
    dat_i <= d;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1) failures++;
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdChk(input string what, input logic [7:0] a,
                       input logic [31:0] e);
    wb(a, 1'b0, 4'hf, 32'h0);
    checkReg(what, e, rd);
  endtask

  // ==========================================================
  // Expected pattern CRC, worked out bit by bit, MSB first
  function automatic logic [15:0] crcOf(input logic [7:0] b0, b1);
    logic [15:0] c;
    logic [7:0]  b;
    c = wake_pkg::CRC_INIT;
    for (int k = 0; k < 16; k++) begin
      b = k < 8 ? b0 : b1;
      c = {c[14:0], 1'b0} ^
          ((c[15] ^ b[7 - k % 8]) ? wake_pkg::CRC_POLY : 16'h0);
    end
    return c;
  endfunction

  // ==========================================================
  // Frame builder: kind 0 own, 1 multicast, 2 broadcast, 3 other unicast
  task automatic mkFrame(input int kind, input logic [7:0] p14,
                         input int copies);
    logic [47:0] da;
    da = kind == 0 ? nodeAddr : kind == 1 ? {8'h01, nodeAddr[39:0]} :
         kind == 2 ? 48'hffff_ffff_ffff : nodeAddr ^ 48'h1;
    u_mac_rx_model.frame.delete();
    for (int i = 5; i >= 0; i--) u_mac_rx_model.frame.push_back(da[8*i +: 8]);
    for (int i = 6; i < 25; i++) u_mac_rx_model.frame.push_back(8'($urandom));
    u_mac_rx_model.frame[14] = p14;
    u_mac_rx_model.frame[16] = 8'h3c;
    // Sync run first, then the address copies
    for (int i = 0; i < 6 && copies > 0; i++) u_mac_rx_model.frame.push_back(8'hff);
    for (int i = 0; i < 6 * copies; i++)
      u_mac_rx_model.frame.push_back(nodeAddr[47 - 8 * (i % 6) -: 8]);
    u_mac_rx_model.frame.push_back(8'h5a);
  endtask

  // One filter case: set control and filter 5 command, then send
  task automatic row(input int kind, input logic pass, uni,
                     input logic [3:0] cmd, input logic fen, ok, good, exp);
    wb(wake_pkg::OFF_CTRL, 1'b1, 4'hf, {22'h0, uni, 7'h0, fen, 1'b0});
    wb(wake_pkg::OFF_CMD, 1'b1, 4'hf, {8'h0, cmd, 20'h0});
    mkFrame(kind, good ? 8'ha7 : 8'ha6, 0);
    notes.push_back({exp, exp, 1'b0});
    u_mac_rx_model.sendFrame(ok, pass);
  endtask
  task automatic mg(input int kind, input int copies, input logic exp);
    mkFrame(kind, 8'h00, copies);
    notes.push_back({3{exp}});
    u_mac_rx_model.sendFrame(1'b1, 1'b0);
  endtask

  // ==========================================================
  // Result watcher: the pulse launches one edge after the last byte
  always begin
    @(posedge clk);
    if (rxValid === 1'b1 && rxEof === 1'b1) begin
      @(posedge clk);
      #1;
      if (notes.size() == 0) checkReg("unexpected frame", 0, 1);
      else checkWake(notes.pop_front(), {wakeRequest, remoteWakeup, fullPowerReq});
    end
  end

  // Watchdog; generous against a hang on the bus or stream
  initial begin
    #1_000_000;
    failures++;
    results();
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(63));
    failures = 0;
    num_checks = 0;
    rst_n = 1'b0;
    adr_i = 8'h00;
    dat_i = 32'h0;
    sel_i = 4'h0;
    we_i = 1'b0;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    nodeAddr = {16'($urandom), 32'($urandom)} & 48'hfeff_ffff_ffff;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdChk("ctrl reset", wake_pkg::OFF_CTRL, wake_pkg::CTRL_RESET);
    rdChk("istat reset", wake_pkg::OFF_ISTAT, 32'h0);
    rdChk("imask reset", wake_pkg::OFF_IMASK, 32'h0);
    rdChk("cmd reset", wake_pkg::OFF_CMD, 32'h0);
    rdChk("unmapped", 8'hfc, 32'h0);
    wb(wake_pkg::OFF_CMD, 1'b1, 4'hf, 32'hffff_ffff);
    rdChk("cmd bits", wake_pkg::OFF_CMD, wake_pkg::CMD_WMASK);
    // Filter 5: offset 14 via byte lane 1 only, mask bytes 14 and 16
    wb(wake_pkg::OFF_OFFS1, 1'b1, 4'h2, 32'hffff_0eff);
    rdChk("offset", wake_pkg::OFF_OFFS1, 32'h0000_0e00);
    wb(8'h20, 1'b1, 4'hf, {crcOf(8'ha7, 8'h3c), 16'h0});
    for (int w = 0; w < 4; w++) wb(8'h90 + 8'(4 * w), 1'b1, 4'hf, w == 0 ? 32'h5 : 32'h0);
    wb(wake_pkg::OFF_IMASK, 1'b1, 4'hf, 32'h3);
    row(2, 0, 0, 4'h1, 1, 1, 1, 1);
    checkReg("irq raised", 1, irq);
    rdChk("istat frame", wake_pkg::OFF_ISTAT, 32'h2);
    checkReg("irq cleared", 0, irq);
    row(3, 0, 1, 4'h9, 1, 1, 1, 1);
    row(3, 0, 0, 4'h1, 1, 1, 1, 0);
    row(1, 1, 0, 4'h9, 1, 1, 1, 1);
    row(1, 1, 0, 4'h1, 1, 1, 1, 0);
    row(0, 1, 0, 4'h1, 1, 1, 1, 1);
    row(3, 1, 0, 4'h9, 1, 1, 1, 0);
    row(1, 1, 0, 4'h5, 1, 1, 1, 1);
    row(0, 1, 0, 4'hd, 1, 1, 1, 1);
    row(1, 0, 0, 4'h5, 1, 1, 1, 0);
    row(2, 0, 0, 4'h2, 1, 1, 1, 0);
    row(2, 0, 0, 4'h1, 1, 1, 0, 0);
    row(2, 0, 0, 4'h1, 0, 1, 1, 0);
    row(2, 0, 0, 4'h1, 1, 0, 1, 0);
    wb(wake_pkg::OFF_IMASK, 1'b1, 4'hf, 32'h0);
    checkReg("irq masked", 0, irq);
    rdChk("istat masked", wake_pkg::OFF_ISTAT, 32'h2);
    wb(wake_pkg::OFF_IMASK, 1'b1, 4'hf, 32'h3);
    // Magic packet mode
    wb(wake_pkg::OFF_CTRL, 1'b1, 4'hf, 32'h1);
    checkReg("rx disabled", 1, rxDisable);
    mg(0, 16, 1);
    rdChk("magic flag", wake_pkg::OFF_CTRL, 32'h31);
    rdChk("istat magic", wake_pkg::OFF_ISTAT, 32'h1);
    mg(3, 16, 0);
    mg(1, 16, 1);
    mg(2, 15, 0);
    mg(2, 16, 1);
    wb(wake_pkg::OFF_CTRL, 1'b1, 4'hf, 32'h30);
    rdChk("ctrl cleared", wake_pkg::OFF_CTRL, 32'h0);
    checkReg("rx enabled", 0, rxDisable);
    results();
  end
endmodule
